// ---- hw/ssr_core.sv ----
// Synchronous burst SRAM core with stop-clock and non-burst operation
// Behaviour
// R1 - All state and data held unchanged while the clock is stopped.
// R2 - Operation resumes on the first edge that carries an address strobe.
// R3 - Controller stops clock only after final write captured or read driven.
// R4 - Controller parks clock low, controls inactive, then addresses low; the bench stop leaves cas_n low, selects active and ao at ad[2].
// R5 - Controller holds data inputs at fixed levels while clock is stopped.
// R6 - Controller drives data inputs low during a deselected stop.
// R7 - Write when global write low, or write enable low with any byte low.
// R8 - Enabled only with select_first low, second high, third low at strobe.
// R9 - Non-burst mode: counter unused, each cycle uses a fresh address.
// R10 - Non-burst ties: processor strobe high, controller strobe low, advance high.
// R11 - Burst order: linear modulo four when low, interleaved xor when high.
// R12 - In non-burst ties the external address loads on every edge.
`timescale 1ns/1ps
module ssr_core #(
	parameter int ADDR_W = ssr_pkg::ADDR_W_DEF,
	parameter int BYTES  = ssr_pkg::BYTES_DEF
) (
	input  wire logic                 mclk,                    // Clock
	input  wire logic                 reset,                   // Async reset, high
	input  wire logic                 processor_addr_strobe_n, // Processor strobe, low
	input  wire logic                 controller_addr_strobe_n,// Controller strobe, low
	input  wire logic                 burst_advance_n,         // Advance, low
	input  wire logic                 select_first_n,          // Select, low
	input  wire logic                 select_second,           // Select, high
	input  wire logic                 select_third_n,          // Select, low
	input  wire logic                 global_write_n,          // All-byte write, low
	input  wire logic                 write_enable_n,          // Byte write enable, low
	input  wire logic [BYTES-1:0]     byte_write_n,            // Byte strobes, low
	input  wire logic                 burst_order_select,      // 0 linear, 1 interleaved
	input  wire logic [ADDR_W-1:0]    addr,                    // External address
	input  wire logic [8*BYTES-1:0]   data_in,                 // Write data
	output logic      [8*BYTES-1:0]   data_out,                // Read data
	output logic                      data_oe,                 // Read data valid
	output logic      [ADDR_W-1:0]    cur_addr,                // Address in use
	output logic                      selected                 // Device enabled
);
	localparam int DEPTH = 1 << ADDR_W;

	logic [8*BYTES-1:0]   mem_r [DEPTH];
	ssr_pkg::ssr_state_t  state_r;
	ssr_pkg::ssr_state_t  state_nxt;
	logic [ADDR_W-1:0]    base_r;
	logic [1:0]           step_r;
	logic [1:0]           step_nxt;
	logic [ADDR_W-1:0]    addr_nxt;
	logic                 strobe;
	logic                 enable;
	logic                 is_write;
	logic [BYTES-1:0]     lane_we;

	// Burst address from start address and step
	function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] step,
		input logic order);
		burst_low = order ? (start ^ step) : 2'(start + step);	// R11
	endfunction : burst_low

	// Processor strobe still counts while deselected by select_first
	assign strobe   = !processor_addr_strobe_n || !controller_addr_strobe_n;	// R2
	assign enable   = !select_first_n && select_second && !select_third_n;	// R8
	assign is_write = !global_write_n || (!write_enable_n && !(&byte_write_n));	// R7
	assign lane_we  = !global_write_n ? {BYTES{1'b1}} : (write_enable_n ? '0 : ~byte_write_n);

	// Next state and address: strobe loads external address, else continue
	always_comb begin
		state_nxt = state_r;
		step_nxt  = step_r;
		addr_nxt  = cur_addr;
		if (strobe) begin
			step_nxt  = ssr_pkg::STEP_ZERO;
			addr_nxt  = addr;	// R9 R12
			if (!enable)
				state_nxt = ssr_pkg::SSR_IDLE;	// R8
			else if (is_write && processor_addr_strobe_n)
				state_nxt = ssr_pkg::SSR_WRITE;
			else
				state_nxt = ssr_pkg::SSR_READ;
		end else if (state_r != ssr_pkg::SSR_IDLE) begin
			state_nxt = is_write ? ssr_pkg::SSR_WRITE : ssr_pkg::SSR_READ;
			if (!burst_advance_n) begin
				step_nxt = 2'(step_r + ssr_pkg::STEP_ONE);
				addr_nxt = {base_r[ADDR_W-1:2],
					burst_low(base_r[1:0], step_nxt, burst_order_select)};	// R11
			end
		end
	end

	// No clock means no update; everything is edge-held storage
	always_ff @(posedge mclk or posedge reset) begin	// R1
		if (reset) begin
			state_r  <= ssr_pkg::SSR_IDLE;
			step_r   <= ssr_pkg::STEP_ZERO;
			base_r   <= '0;
			cur_addr <= '0;
			selected <= ssr_pkg::RST_LOW;
		end else begin
			state_r  <= state_nxt;
			step_r   <= step_nxt;
			cur_addr <= addr_nxt;
			selected <= state_nxt != ssr_pkg::SSR_IDLE;
			if (strobe)
				base_r <= addr;
		end
	end

	// Array write uses current cycle address and data
	always_ff @(posedge mclk) begin
		if (state_nxt == ssr_pkg::SSR_WRITE) begin
			for (int b = 0; b < BYTES; b++) begin
				if (lane_we[b])
					mem_r[addr_nxt][8*b +: 8] <= data_in[8*b +: 8];	// R7
			end
		end
	end

	// Registered read output, stays driven until next edge
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			data_out <= '0;
			data_oe  <= ssr_pkg::RST_LOW;
		end else begin
			data_oe  <= state_nxt == ssr_pkg::SSR_READ;
			if (state_nxt == ssr_pkg::SSR_READ)
				data_out <= mem_r[addr_nxt];
		end
	end

	non_burst_load_a: assert property (@(posedge mclk) disable iff (reset)	// R12
		(!controller_addr_strobe_n && enable) |=> cur_addr == $past(addr))
		else $error("address not loaded on strobe");
	select_gate_a: assert property (@(posedge mclk) disable iff (reset)	// R8
		(strobe && !enable) |=> !selected && !data_oe)
		else $error("enabled without full select");
	write_qual_a: assert property (@(posedge mclk) disable iff (reset)	// R7
		(strobe && enable && processor_addr_strobe_n && !global_write_n) |=> !data_oe)
		else $error("global write read back");
	read_drive_a: assert property (@(posedge mclk) disable iff (reset)	// R2
		(strobe && enable && global_write_n && write_enable_n) |=> data_oe && selected)
		else $error("no resume on strobe");
	linear_step_a: assert property (@(posedge mclk) disable iff (reset)	// R11
		(!strobe && selected && !burst_advance_n && !burst_order_select)
		|=> cur_addr[1:0] == 2'($past(base_r[1:0]) + $past(step_r) + 2'h1))
		else $error("linear burst wrong");
	interleave_step_a: assert property (@(posedge mclk) disable iff (reset)	// R11
		(!strobe && selected && !burst_advance_n && burst_order_select)
		|=> cur_addr[1:0] == ($past(base_r[1:0]) ^ 2'($past(step_r) + 2'h1)))
		else $error("interleaved burst wrong");
	hold_addr_a: assert property (@(posedge mclk) disable iff (reset)	// R1
		(!strobe && burst_advance_n) |=> $stable(cur_addr))
		else $error("address moved while suspended");
	deselect_stay_a: assert property (@(posedge mclk) disable iff (reset)	// R9
		(!strobe && !selected) |=> !selected)
		else $error("selected without strobe");

	// Strobe edges: address and base load from the pins, step clears to zero
	resume_addr_a: assert property (@(posedge mclk) disable iff (reset)	// R2
		strobe |=> cur_addr == $past(addr))
		else $error("strobe did not load address");
	resume_step_a: assert property (@(posedge mclk) disable iff (reset)	// R2
		strobe |=> step_r == ssr_pkg::STEP_ZERO)
		else $error("burst step not cleared on strobe");
	base_load_a: assert property (@(posedge mclk) disable iff (reset)	// R2
		strobe |=> base_r == $past(addr))
		else $error("burst base not loaded on strobe");

	// Write qualification; a write begun by the controller strobe shows no read data in the cycle after its edge
	write_all_a: assert property (@(posedge mclk) disable iff (reset)	// R7
		(strobe && enable && processor_addr_strobe_n && !global_write_n) |=> selected)
		else $error("global write left device deselected");
	byte_write_a: assert property (@(posedge mclk) disable iff (reset)	// R7
		(strobe && enable && processor_addr_strobe_n && global_write_n && !write_enable_n
		&& !(&byte_write_n)) |=> !data_oe)
		else $error("byte write read back");
	no_lane_read_a: assert property (@(posedge mclk) disable iff (reset)	// R7
		(strobe && enable && global_write_n && !write_enable_n && (&byte_write_n))
		|=> data_oe)
		else $error("enable without byte lanes not a read");
	proc_read_a: assert property (@(posedge mclk) disable iff (reset)	// R7
		(strobe && enable && !processor_addr_strobe_n) |=> data_oe)
		else $error("processor strobe did not begin a read");

	// Each select alone is enough to refuse the cycle
	first_select_a: assert property (@(posedge mclk) disable iff (reset)	// R8
		(strobe && select_first_n) |=> !selected)
		else $error("enabled with first select high");
	second_select_a: assert property (@(posedge mclk) disable iff (reset)	// R8
		(strobe && !select_second) |=> !selected)
		else $error("enabled with second select low");
	third_select_a: assert property (@(posedge mclk) disable iff (reset)	// R8
		(strobe && select_third_n) |=> !selected)
		else $error("enabled with third select high");
	enable_sel_a: assert property (@(posedge mclk) disable iff (reset)	// R8
		(strobe && enable) |=> selected)
		else $error("full select ignored");
	oe_select_a: assert property (@(posedge mclk) disable iff (reset)	// R8
		data_oe |-> selected)
		else $error("read data while deselected");
	state_onehot_a: assert property (@(posedge mclk) disable iff (reset)	// R8
		$onehot(state_r))
		else $error("state code not one-hot");

	// Non-burst ties: counter stays at its start value
	fresh_addr_a: assert property (@(posedge mclk) disable iff (reset)	// R9
		(!controller_addr_strobe_n && burst_advance_n)
		|=> cur_addr == $past(addr) && step_r == ssr_pkg::STEP_ZERO)
		else $error("counter used in non-burst mode");

	// Suspended or idle cycles must not disturb held state
	stop_step_a: assert property (@(posedge mclk) disable iff (reset)	// R1
		(!strobe && burst_advance_n) |=> $stable(step_r) && $stable(base_r))
		else $error("burst state moved while suspended");
	idle_hold_a: assert property (@(posedge mclk) disable iff (reset)	// R1
		(!strobe && !selected) |=> $stable(cur_addr))
		else $error("address moved while deselected");

	// Only the two low bits take part in a burst
	burst_upper_a: assert property (@(posedge mclk) disable iff (reset)	// R11
		(!strobe && selected && !burst_advance_n)
		|=> cur_addr[ADDR_W-1:2] == $past(base_r[ADDR_W-1:2]))
		else $error("burst changed upper address bits");
endmodule : ssr_core

// ---- hw/ssr_pkg.sv ----
// Shared constants for the synchronous burst SRAM core
package ssr_pkg;
	localparam int ADDR_W_DEF  = 10;	// Address width default
	localparam int BYTES_DEF   = 8;	// Byte lanes default
	localparam logic [1:0] STEP_ONE = 2'h1;	// Burst step increment
	localparam logic [1:0] STEP_ZERO = 2'h0;	// Burst step at start
	localparam logic       RST_LOW  = 1'h0;	// Reset value of flags
	typedef enum logic [2:0] {
		SSR_IDLE  = 3'b001,
		SSR_READ  = 3'b010,
		SSR_WRITE = 3'b100
	} ssr_state_t;
endpackage : ssr_pkg

// ---- test/ssr_ctrl_model.sv ----
// Controller model driving the SRAM pins non-burst: processor strobe and advance high, controller strobe low except on idle ops
`timescale 1ns/1ps
module ssr_ctrl_model (
	input  wire logic [1:0]  op,    // 0 idle, 1 read, 2 write, 3 byte write
	input  wire logic        sel,   // Selects complete
	input  wire logic [9:0]  a,     // Address
	input  wire logic [63:0] d,     // Write data
	input  wire logic [7:0]  be,    // Byte strobes, low
	output logic             pas_n, // Processor strobe
	output logic             cas_n, // Controller strobe
	output logic             adv_n, // Advance
	output logic             s1_n,  // First select
	output logic             s2,    // Second select
	output logic             s3_n,  // Third select
	output logic             gw_n,  // Global write
	output logic             we_n,  // Write enable
	output logic             ord_sel, // Burst order
	output logic [7:0]       bw_n,  // Byte strobes to device
	output logic [9:0]       ao,    // Address to device
	output logic [63:0]      dq     // Data to device
);
	assign pas_n = 1'h1;
	assign cas_n = op == 2'h0;
	assign adv_n = 1'h1;
	assign s1_n = 1'h0;
	assign s2 = 1'h1;
	assign s3_n = ~sel;
	assign gw_n = op != 2'h2;
	assign we_n = op != 2'h3;
	assign bw_n = op == 2'h3 ? be : 8'hff;
	assign ord_sel = 1'h0;
	assign ao = op == 2'h0 ? 10'h0 : a;
	assign dq = op == 2'h0 ? 64'h0 : d;
endmodule : ssr_ctrl_model

// ---- test/tb_ssr_core.sv ----
// Self-checking bench for the SRAM core
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_ssr_core;
	logic mclk = 0, reset = 1, run = 1, sel_r = 0;
	logic pas_n, cas_n, adv_n, s1_n, s2, s3_n, gw_n, we_n, ord_sel, data_oe, selected;
	logic [1:0] op_r = 2'h0;
	logic [7:0] be_r = 8'hff, bw_n;
	logic [9:0] a_r = 10'h0, ao, cur_addr, ca, ad [8];
	logic [63:0] d_r = 64'h0, dq, data_out, so, mem [logic [9:0]];
	int compares = 0, failures = 0, cycles = 0, seed = 32'h390d123b;
	ssr_ctrl_model model (.op(op_r), .sel(sel_r), .a(a_r), .d(d_r), .be(be_r), .pas_n, .cas_n,
		.adv_n, .s1_n, .s2, .s3_n, .gw_n, .we_n, .ord_sel, .bw_n, .ao, .dq);
	ssr_core #(.ADDR_W(10), .BYTES(8)) DUT (.mclk, .reset, .processor_addr_strobe_n(pas_n),
		.controller_addr_strobe_n(cas_n), .burst_advance_n(adv_n), .select_first_n(s1_n),
		.select_second(s2), .select_third_n(s3_n), .global_write_n(gw_n), .write_enable_n(we_n),
		.byte_write_n(bw_n), .burst_order_select(ord_sel), .addr(ao), .data_in(dq), .data_out,
		.data_oe, .cur_addr, .selected);
	initial forever begin
		#20;
		mclk = run ? ~mclk : 1'b0;
	end
	function automatic logic [63:0] merge(input logic [63:0] o, d, input logic [7:0] b);
		for (int i = 0; i < 8; i++) if (!b[i]) o[8*i +: 8] = d[8*i +: 8];
		return o;
	endfunction : merge
	task automatic conclude;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	// Old command is what the core samples at this edge
	task automatic step(input logic [1:0] op, input logic sel, input logic [9:0] a,
		input logic [63:0] d, input logic [7:0] b);
		logic [1:0] o;
		logic s, w;
		logic [9:0] x;
		logic [63:0] v, e;
		logic [7:0] m;
		@(posedge mclk);
		{o, s, x, v, m} = {op_r, sel_r, a_r, d_r, be_r};
		{op_r, sel_r, a_r, d_r, be_r} <= {op, sel, a, d, b};
		#1;
		w = o == 2'h2 || (o == 2'h3 && m != 8'hff);
		e = mem.exists(x) ? mem[x] : 64'h0;
		if (o != 2'h0) `CHK(data_oe, s && !w)
		if (o != 2'h0 && s && !w) `CHK(data_out, e)
		if (o != 2'h0) `CHK(selected, s)
		if (o != 2'h0 && s) `CHK(cur_addr, x)
		if (w && s) mem[x] = merge(e, v, o == 2'h2 ? 8'h00 : m);
	endtask : step
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 1000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		for (int i = 0; i < 8; i++) ad[i] = 10'($random(seed));
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		for (int i = 0; i < 8; i++) step(2'h2, 1, ad[i], {$random(seed), $random(seed)}, 8'hff);
		for (int i = 0; i < 8; i++) step(2'h3, 1, ad[i], {$random(seed), $random(seed)}, ~(8'h1 << i));
		step(2'h3, 1, ad[0], 64'h0, 8'hff);
		step(2'h2, 0, ad[1], 64'h0, 8'h00);
		for (int i = 0; i < 8; i++) step(2'h1, 1, ad[i], 64'h0, 8'hff);
		$display("directed writes and reads done");
		step(2'h1, 1, ad[2], 64'h0, 8'hff);
		run = 0;
		so = data_out;
		ca = cur_addr;
		#400;
		`CHK(data_out, so)
		`CHK(cur_addr, ca)
		run = 1;
		repeat (60) step(2'($random(seed)), (($random(seed) & 3) != 0), ad[3'($random(seed))],
			{$random(seed), $random(seed)}, 8'($random(seed)));
		repeat (2) step(2'h0, 0, 10'h0, 64'h0, 8'hff);
		$display("stop clock and random mix done");
		conclude();
	end
endmodule : tb_ssr_core
